// ==== dv/pbm_checker.sv ====
// Assertion checker bound to the port B pin mux
`default_nettype none
module pbm_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       funcSelWrEn,
  input wire logic [7:0] funcSelWrData,
  input wire logic [7:0] portBFunctionSelect,
  input wire logic       pullupWrEn,
  input wire logic [7:0] pullupWrData,
  input wire logic [7:0] pinPullupEn,
  input wire logic       busDriveHold,
  input wire logic [3:0] clockOutSelect,
  input wire logic       extBusActive,
  input wire logic [7:0] extAddrHigh,
  input wire logic [7:0] gpioDataOut,
  input wire logic [7:0] gpioDirOut,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOutEn,
  input wire logic       bootSelectDone
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [7:0] sel = portBFunctionSelect;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_boot_idle;
    !bootSelectDone;
  endsequence
  sequence s_hi_periph;
    bootSelectDone && sel[7:4] == 4'h0;
  endsequence
  // The release edge still sees the mux in reset, so a write there is not taken
  a_sel_write: assert property (
    reset_n && funcSelWrEn |=> sel == $past(funcSelWrData)) else $error("select write lost");
  a_pullup_write: assert property (
    reset_n && pullupWrEn |=> pinPullupEn == $past(pullupWrData))
    else $error("pull-up write lost");
  a_low_addr: assert property (
    bootSelectDone && sel[3:0] == 4'h0 |=> pinOut[3:0] == $past(extAddrHigh[3:0]))
    else $error("low address wrong");
  a_high_addr: assert property (
    s_hi_periph and clockOutSelect == 4'h0 |=> pinOut[7:4] == $past(extAddrHigh[7:4]))
    else $error("high address wrong");
  a_idle_drive: assert property (
    bootSelectDone && !sel[0] |=> pinOutEn[0] == ($past(extBusActive) | $past(busDriveHold)))
    else $error("address drive wrong");
  a_clock_drive: assert property (
    s_hi_periph and clockOutSelect == 4'hF |=> pinOutEn[7:4] == 4'hF)
    else $error("clock tap not driven");
  a_gpio_follow: assert property (
    bootSelectDone && sel == 8'hFF |=> pinOut == $past(gpioDataOut)
    && pinOutEn == $past(gpioDirOut)) else $error("gpio not followed");
  a_boot_quiet: assert property (
    s_boot_idle |-> pinOutEn == 8'h00 && sel[7:4] == 4'hF) else $error("pins active in boot");
endmodule
bind pbm_pin_mux pbm_checker chk_u (
  .clk                 (clk),
  .reset_n             (reset_n),
  .funcSelWrEn         (funcSelWrEn),
  .funcSelWrData       (funcSelWrData),
  .portBFunctionSelect (portBFunctionSelect),
  .pullupWrEn          (pullupWrEn),
  .pullupWrData        (pullupWrData),
  .pinPullupEn         (pinPullupEn),
  .busDriveHold        (busDriveHold),
  .clockOutSelect      (clockOutSelect),
  .extBusActive        (extBusActive),
  .extAddrHigh         (extAddrHigh),
  .gpioDataOut         (gpioDataOut),
  .gpioDirOut          (gpioDirOut),
  .pinOut              (pinOut),
  .pinOutEn            (pinOutEn),
  .bootSelectDone      (bootSelectDone)
);
`default_nettype wire

// ==== dv/pbm_mem_model.sv ====
// Pin-side partner: levels the external memory side presents on port B
`default_nettype none
module pbm_mem_model (
  input  wire logic       clk,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOutEn,
  input  wire logic [7:0] pinPullupEn,
  output logic [7:0]      pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] toggle_r = 8'h5A;
  // Floating lines without pull-up toggle so a stale level never passes for a real one
  always @(posedge clk) toggle_r <= ~toggle_r;
  assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & (pinPullupEn | toggle_r));
endmodule
`default_nettype wire

// ==== dv/test_port_b_upper_address_pin_mux.sv ====
// Self-checking bench for the port B pin mux
`default_nettype none
module test_port_b_upper_address_pin_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n, externalBootPin, extMemifMode, flashSecured, funcSelWrEn, pullupWrEn;
  logic busDriveHold, extBusActive, prescalerClock, systemClockOut, systemClockSecondOut;
  logic oscillatorClock, bootSelectDone;
  logic [7:0] funcSelWrData, pullupWrData, extAddrHigh, gpioDataOut, gpioDirOut, pinIn;
  logic [7:0] portBFunctionSelect, gpioDataIn, pinOut, pinOutEn, pinPullupEn, r;
  logic [7:0] mSel, mPu, mO, mE, mI, ck, ad, tap;
  logic [3:0] clockOutSelect;
  logic [15:0] lf = 16'hF75C;
  int n_mismatch = 0, checked = 0, ph = 0;
  pbm_pin_mux dut_u (.*);
  pbm_mem_model mem_u (.*);
  assign tap = {oscillatorClock, systemClockSecondOut, systemClockOut, prescalerClock, 4'h0};
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // Bench model, updated on the same edges as the mux
  // ****************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {ph, mSel, mPu, mO, mE, mI} = {32'd0, 16'hFFFF, 24'h0};
    end else begin
      ck = ~mSel & {clockOutSelect, 4'h0};
      ad = ~mSel & ~ck;
      mO = ph ? (mSel & gpioDataOut | ck & tap | ad & extAddrHigh) : 8'h00;
      mE = ph ? (mSel & gpioDirOut | ck | ad & {8{extBusActive | busDriveHold}}) : 8'h00;
      mI = pinIn;
      if (ph == 0) mSel[3:0] = (externalBootPin | extMemifMode & ~flashSecured) ? 4'h0 : 4'hF;
      if (funcSelWrEn) mSel = funcSelWrData;
      if (pullupWrEn) mPu = pullupWrData;
      ph = 1;
    end
  end
  always @(negedge clk) begin
    chk("pinOut", pinOut, mO);
    chk("pinOutEn", pinOutEn, mE);
    chk("funcSel", portBFunctionSelect, mSel);
    chk("pullup", pinPullupEn, mPu);
    chk("dataIn", gpioDataIn, mI);
    chk("bootDone", {7'h0, bootSelectDone}, 8'(ph));
  end
  initial begin
    {reset_n, funcSelWrEn, pullupWrEn, extBusActive, clockOutSelect} = '0;
    {prescalerClock, systemClockOut, systemClockSecondOut, oscillatorClock} = '0;
    {funcSelWrData, pullupWrData, extAddrHigh, gpioDataOut, gpioDirOut} = '0;
    busDriveHold = 1'b1;
    for (int k = 0; k < 8; k++) begin
      reset_n <= 1'b0;
      {externalBootPin, extMemifMode, flashSecured} <= 3'(k);
      repeat (k == 0 ? 20 : 3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (150) begin
        @(posedge clk);
        gpioDataOut <= rnd();
        gpioDirOut <= rnd();
        extAddrHigh <= rnd();
        pullupWrData <= rnd();
        {extBusActive, busDriveHold, prescalerClock, systemClockOut} <= 4'(rnd());
        {systemClockSecondOut, oscillatorClock} <= 2'(rnd());
        r = rnd();
        // Whole-nibble values reach the address and clock cases often
        clockOutSelect <= r[0] ? {4{r[1]}} : r[7:4];
        funcSelWrEn <= r[2] & r[3];
        pullupWrEn <= r[4] & r[5];
        r = rnd();
        funcSelWrData <= r[0] ? {{4{r[1]}}, {4{r[2]}}} : r;
      end
      $display("test straps %0d done", k);
    end
    summarize();
  end
endmodule
`default_nettype wire

// ==== rtl/pbm_pin_mux.sv ====
// Port B lines 0-7 function mux: GPIO, upper address bits 16-23, clock observation on lines 4-7
`default_nettype none

module pbm_pin_mux (
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Reset-time straps
  input  wire logic             externalBootPin,
  input  wire logic             extMemifMode,
  input  wire logic             flashSecured,
  // Software function-select write
  input  wire logic             funcSelWrEn,
  input  wire pbm_pkg::pbm_line_t funcSelWrData,
  output logic [7:0]            portBFunctionSelect,
  // Software pull-up enable write
  input  wire logic             pullupWrEn,
  input  wire pbm_pkg::pbm_line_t pullupWrData,
  // External bus control and clock-out select levels
  input  wire logic             busDriveHold,
  input  wire pbm_pkg::pbm_nib_t clockOutSelect,
  // External memory interface
  input  wire logic             extBusActive,
  input  wire pbm_pkg::pbm_line_t extAddrHigh,
  // GPIO core side
  input  wire pbm_pkg::pbm_line_t gpioDataOut,
  input  wire pbm_pkg::pbm_line_t gpioDirOut,
  output logic [7:0]            gpioDataIn,
  // Internal clocks for observation
  input  wire logic             prescalerClock,
  input  wire logic             systemClockOut,
  input  wire logic             systemClockSecondOut,
  input  wire logic             oscillatorClock,
  // Pins
  input  wire pbm_pkg::pbm_line_t pinIn,
  output logic [7:0]            pinOut,
  output logic [7:0]            pinOutEn,
  output logic [7:0]            pinPullupEn,
  output logic                  bootSelectDone
);
  import pbm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  pbm_boot_e bootState_r;
  pbm_line_t funcSel_r;
  pbm_line_t pullup_r;
  pbm_line_t pinOut_r;
  pbm_line_t pinOutEn_r;
  pbm_line_t gpioIn_r;

  pbm_line_t pinOut_nxt;
  pbm_line_t pinOutEn_nxt;
  pbm_nib_t  clockTap;
  pbm_line_t clkPick;
  pbm_line_t clkLine;
  logic      strapWantsAddr;
  logic      addrDrive;

  // ****************************************************************
  // Reset-time function selection
  // ****************************************************************
  // Straps are taken on the first edge after release, never under reset,
  // so the asynchronous reset only ever loads constants.
  // Address lines are wanted when booting externally, or when the memory
  // interface mode asks for them and the flash is not secured.
  assign strapWantsAddr = externalBootPin | (extMemifMode & ~flashSecured);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bootState_r <= PBM_BOOT_WAIT;
    end else begin
      bootState_r <= PBM_BOOT_DONE;
    end
  end

  assign bootSelectDone = (bootState_r == PBM_BOOT_DONE);

  // ****************************************************************
  // Function select register
  // ****************************************************************
  // A software write on the strap edge wins, so software always has the
  // last word on every line.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      funcSel_r <= FUNC_SEL_RST;
    end else if (funcSelWrEn) begin
      funcSel_r <= funcSelWrData;
    end else begin
      unique case (bootState_r)
        PBM_BOOT_WAIT: begin
          funcSel_r[LOW_COUNT-1:0] <= strapWantsAddr ? LOW_ADDR_SEL : LOW_GPIO_SEL;
        end
        PBM_BOOT_DONE: begin
          funcSel_r <= funcSel_r;
        end
      endcase
    end
  end

  assign portBFunctionSelect = funcSel_r;

  // ****************************************************************
  // Pull-up enable register
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_r <= PULLUP_RST;
    end else if (pullupWrEn) begin
      pullup_r <= pullupWrData;
    end
  end

  // Pull-up only matters while the pin is not driven by this block
  assign pinPullupEn = pullup_r;

  // ****************************************************************
  // Output mux
  // ****************************************************************
  // Clock taps are sampled on clk, so an observed clock faster than half
  // of clk aliases; this is a monitor, not a clean clock forward.
  assign clockTap = {oscillatorClock, systemClockSecondOut,
                     systemClockOut, prescalerClock};

  // Spread over all eight lines so the loop can index every line; lines 0-3 never pick a clock
  assign clkPick = {clockOutSelect ~^ {CLK_SRC_CNT{CLKSEL_CLOCK}}, 4'h0};
  assign clkLine = {clockTap, 4'h0};

  // Address lines are driven during a bus cycle, or at all times when
  // software holds the drive on; otherwise they float.
  assign addrDrive = extBusActive | busDriveHold;

  always_comb begin
    pinOut_nxt   = PIN_OUT_RST;
    pinOutEn_nxt = PIN_OE_RST;
    for (int i = 0; i < LINE_COUNT; i++) begin
      if (funcSel_r[i]) begin
        pinOut_nxt[i]   = gpioDataOut[i];
        pinOutEn_nxt[i] = gpioDirOut[i];
      end else if (clkPick[i]) begin
        pinOut_nxt[i]   = clkLine[i];
        pinOutEn_nxt[i] = 1'b1;
      end else begin
        // Lines 0-3 carry bits 16-19, lines 4-7 carry bits 20-23
        pinOut_nxt[i]   = extAddrHigh[i];
        pinOutEn_nxt[i] = addrDrive;
      end
    end
  end

  // ****************************************************************
  // Pin output registers
  // ****************************************************************
  // Held at input/tri-state through reset and on the first edge after it,
  // until the strap choice has landed in the function select.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_r   <= PIN_OUT_RST;
      pinOutEn_r <= PIN_OE_RST;
    end else if (bootState_r == PBM_BOOT_WAIT) begin
      pinOut_r   <= PIN_OUT_RST;
      pinOutEn_r <= PIN_OE_RST;
    end else begin
      pinOut_r   <= pinOut_nxt;
      pinOutEn_r <= pinOutEn_nxt;
    end
  end

  assign pinOut   = pinOut_r;
  assign pinOutEn = pinOutEn_r;

  // ****************************************************************
  // Pin input capture
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpioIn_r <= GPIO_IN_RST;
    end else begin
      gpioIn_r <= pinIn;
    end
  end

  assign gpioDataIn = gpioIn_r;

endmodule

`default_nettype wire

// ==== rtl/pbm_pkg.sv ====
// Constants and types shared by the port B upper address pin mux
`default_nettype none

package pbm_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned LINE_COUNT   = 8;
  localparam int unsigned LOW_COUNT    = 4;
  localparam int unsigned CLK_SRC_CNT  = 4;

  typedef logic [LINE_COUNT-1:0]  pbm_line_t;
  typedef logic [CLK_SRC_CNT-1:0] pbm_nib_t;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  // Function select: one means GPIO, zero means peripheral function
  localparam pbm_line_t FUNC_SEL_RST   = 8'hFF;
  localparam pbm_line_t PULLUP_RST     = 8'hFF;
  localparam pbm_line_t PIN_OUT_RST    = 8'h00;
  localparam pbm_line_t PIN_OE_RST     = 8'h00;
  localparam pbm_line_t GPIO_IN_RST    = 8'h00;

  // Low nibble of function select when the straps ask for address lines
  localparam pbm_nib_t  LOW_ADDR_SEL   = 4'h0;
  localparam pbm_nib_t  LOW_GPIO_SEL   = 4'hF;

  // Clock-out select bit value that routes the internal clock to the pin
  localparam logic      CLKSEL_CLOCK   = 1'b1;

  // ****************************************************************
  // Reset-time selection sequencer
  // ****************************************************************
  typedef enum logic [0:0] {
    PBM_BOOT_WAIT,
    PBM_BOOT_DONE
  } pbm_boot_e;

endpackage

`default_nettype wire
